// ==== logic/lfwk_status_regs.sv ====
// Purpose: Status flags, received byte and stored ID of the LF wake-up
//          receiver, reached by software over a plain register port.
// Assumes: Decoder events are one-cycle pulses on clk_sys.
// Notes:   Read data appear in the cycle after the read strobe.
//          A flag event beats an acknowledge that falls in the same cycle.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "lfwk_consts.svh"
module lfwk_status_regs #(
  parameter int unsigned SNIFF_EXTRA_CYC = `LFWK_SNIFF_EXTRA_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        dec_byte_valid,
  input  wire logic [7:0]  dec_byte_data,
  input  wire logic        dec_bit_error,
  input  wire logic        dec_eom_violation,
  input  wire logic        dec_carrier_valid,
  input  wire logic        dec_carrier_miss,
  input  wire logic        dec_id_valid,
  input  wire logic [15:0] dec_id_value,
  output logic             irq_req,
  output logic             low_power_sniff_select,
  output logic             carrier_mode_select,
  output logic             toggle_mode_select,
  output logic             data_path_ready,
  output logic             message_accept
);

  logic [7:0] receiver_status_flags_q;
  logic [7:0] receiver_status_flags_d;
  logic [7:0] received_byte_q;
  logic [7:0] stored_id_low_q;
  logic [7:0] stored_id_high_q;
  logic [7:0] ctrl_q;
  logic [7:0] irqen_q;
  logic [7:0] rdata_q;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [2:0] carrier_cnt_q;
  logic [2:0] carrier_cnt_d;
  logic       msg_block_q;
  logic       page_zero;
  logic       wr_status;
  logic       wr_ctrl;
  logic       wr_irqen;
  logic       wr_idh;
  logic       wr_idl;
  logic       rd_data;
  logic       ack_now;
  logic       data_mode;
  logic       byte_take;
  logic       id_chk_en;
  logic       id_eq;
  logic       carrier_hit;
  logic [`LFWK_WAIT_W-1:0] wait_q;
  lfwk_pkg::lfwk_path_t    path_q;

  // Control and enable registers stay visible on both pages so that
  // software can always switch the page back.
  assign page_zero = ~ctrl_q[`LFWK_CTRL_PAGE];
  assign data_mode = ~ctrl_q[`LFWK_CTRL_CARMODE];

  // Page-zero registers vanish from the map while page select is one.
  // Nothing decodes a write to the data address, so such a write leaves
  // the byte and the flags untouched.
  assign wr_status = reg_wr & page_zero
                   & (reg_addr == `LFWK_ADDR_STATUS);
  assign wr_idh    = reg_wr & page_zero
                   & (reg_addr == `LFWK_ADDR_IDH);
  assign wr_idl    = reg_wr & page_zero
                   & (reg_addr == `LFWK_ADDR_IDL);
  assign rd_data   = reg_rd & page_zero
                   & (reg_addr == `LFWK_ADDR_DATA);
  assign wr_ctrl   = reg_wr & (reg_addr == `LFWK_ADDR_CTRL);
  assign wr_irqen  = reg_wr & (reg_addr == `LFWK_ADDR_IRQEN);

  // The acknowledge acts only in the write cycle and is never stored.
  assign ack_now = wr_status & reg_wdata[`LFWK_BIT_ACK];

  // With checking off the comparator reports no match and never
  // filters, so the ID flag stays clear.
  lfwk_id_match u_id_match (
    .id_value        (dec_id_value),
    .id_high_byte    (stored_id_high_q),
    .id_low_byte     (stored_id_low_q),
    .id_check_select (ctrl_q[`LFWK_CTRL_ID_CHECK_SELECT_HI:`LFWK_CTRL_ID_CHECK_SELECT_LO]),
    .check_enabled   (id_chk_en),
    .id_equal        (id_eq)
  );

  // A filtered message is dropped until its end so that no byte of it
  // wakes the processor.
  // An error, the end mark or leaving data mode ends the filtering.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      msg_block_q <= 1'b0;
    end else if (dec_id_valid && data_mode) begin
      msg_block_q <= id_chk_en & ~id_eq;
    end else if (dec_eom_violation || dec_bit_error || !data_mode) begin
      msg_block_q <= 1'b0;
    end
  end

  assign message_accept = ~msg_block_q;
  assign byte_take = dec_byte_valid & ~msg_block_q;

  // The byte register is only overwritten, never cleared by a read;
  // software sees the last byte until the next one lands.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      received_byte_q <= `LFWK_BYTE_ZERO;
    end else if (byte_take) begin
      // Partial bits before an error arrive as an ordinary byte.
      received_byte_q <= dec_byte_data;
    end
  end

  // Toggle mode ignores the count and reports the first validation.
  // A count field of zero behaves as one.
  // A miss restarts the consecutive count; data mode holds it at zero.
  always_comb begin
    carrier_cnt_d = carrier_cnt_q;
    carrier_hit   = 1'b0;
    if (!data_mode && dec_carrier_valid) begin
      if (ctrl_q[`LFWK_CTRL_TOGGLE]) begin
        carrier_hit = 1'b1;
      end else if ((carrier_cnt_q + `LFWK_CC_ONE) >=
                   ctrl_q[`LFWK_CTRL_CC_HI:`LFWK_CTRL_CC_LO]) begin
        carrier_hit   = 1'b1;
        carrier_cnt_d = 3'h0;
      end else begin
        carrier_cnt_d = carrier_cnt_q + `LFWK_CC_ONE;
      end
    end else if (dec_carrier_miss || data_mode) begin
      carrier_cnt_d = 3'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      carrier_cnt_q <= 3'h0;
    end else begin
      carrier_cnt_q <= carrier_cnt_d;
    end
  end

  // Error, overrun and end-of-message are masked in carrier mode at the
  // source, so a stray decoder pulse cannot leave them set.
  always_comb begin
    flag_set = 8'h00;
    flag_clr = 8'h00;
    flag_set[`LFWK_BIT_DR]  = byte_take;
    flag_set[`LFWK_BIT_ERR] = data_mode & dec_bit_error;
    flag_set[`LFWK_BIT_CD]  = carrier_hit;
    flag_set[`LFWK_BIT_ID]  = data_mode & dec_id_valid
                            & id_chk_en & id_eq;
    // Unread means still flagged and not being read in this cycle.
    flag_set[`LFWK_BIT_OV]  = data_mode & byte_take & ~rd_data
                            & receiver_status_flags_q[`LFWK_BIT_DR];
    flag_set[`LFWK_BIT_EOM] = data_mode & dec_eom_violation
                            & (byte_take
                               | receiver_status_flags_q[`LFWK_BIT_DR]);
    for (int i = `LFWK_FLAG_LO; i <= `LFWK_FLAG_HI; i++) begin
      flag_clr[i] = ack_now;
    end
    flag_clr[`LFWK_BIT_DR] = ack_now | rd_data;
  end

  // Each bit's next value is built apart and the whole register is
  // updated in one process, so every bit has a single driver.
  genvar g;
  generate
    for (g = `LFWK_FLAG_LO; g <= `LFWK_FLAG_HI; g++) begin : g_flag
      // Set beats clear: an event landing in the acknowledge or read
      // cycle is reported rather than lost.
      assign receiver_status_flags_d[g] = flag_set[g]
        | (receiver_status_flags_q[g] & ~flag_clr[g]);
    end
  endgenerate

  // Only the sniff select is written by software; each status write loads it from bit 1.
  assign receiver_status_flags_d[`LFWK_BIT_SNIFF] = wr_status
    ? reg_wdata[`LFWK_BIT_SNIFF]
    : receiver_status_flags_q[`LFWK_BIT_SNIFF];

  // The acknowledge position holds no state: it acts in the write
  // cycle through ack_now and reads as zero ever after.
  assign receiver_status_flags_d[`LFWK_BIT_ACK] = 1'b0;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      receiver_status_flags_q <= `LFWK_STATUS_RESET;
    end else begin
      receiver_status_flags_q <= receiver_status_flags_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stored_id_high_q <= `LFWK_BYTE_ZERO;
    end else if (wr_idh) begin
      stored_id_high_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stored_id_low_q <= `LFWK_BYTE_ZERO;
    end else if (wr_idl) begin
      stored_id_low_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= `LFWK_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqen_q <= `LFWK_IRQEN_RESET;
    end else if (wr_irqen) begin
      irqen_q <= reg_wdata;
    end
  end

  // Overrun and end-of-message have no enable: data-ready and error
  // already announce those events.
  // The request is a plain level that drops as soon as a flag or its
  // enable is cleared.
  assign irq_req =
      (receiver_status_flags_q[`LFWK_BIT_DR] & irqen_q[`LFWK_BIT_DR])
    | (receiver_status_flags_q[`LFWK_BIT_ERR] & irqen_q[`LFWK_BIT_ERR])
    | (receiver_status_flags_q[`LFWK_BIT_ID] & irqen_q[`LFWK_BIT_ID]);

  // Leaving carrier mode: the low-power sniff costs an extra wait
  // before the data path is declared ready.
  // A return to carrier mode during the wait abandons it, and the next
  // change to data mode starts the full wait again.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      path_q <= lfwk_pkg::LFWK_PATH_CARRIER;
      wait_q <= '0;
    end else begin
      case (path_q)
        lfwk_pkg::LFWK_PATH_CARRIER: begin
          if (data_mode) begin
            if (receiver_status_flags_q[`LFWK_BIT_SNIFF]) begin
              path_q <= lfwk_pkg::LFWK_PATH_WAKING;
              wait_q <= `LFWK_WAIT_W'(SNIFF_EXTRA_CYC - 1);
            end else begin
              path_q <= lfwk_pkg::LFWK_PATH_DATA;
            end
          end
        end
        lfwk_pkg::LFWK_PATH_WAKING: begin
          if (!data_mode) begin
            path_q <= lfwk_pkg::LFWK_PATH_CARRIER;
          end else if (wait_q == '0) begin
            path_q <= lfwk_pkg::LFWK_PATH_DATA;
          end else begin
            wait_q <= wait_q - `LFWK_WAIT_W'(1);
          end
        end
        lfwk_pkg::LFWK_PATH_DATA: begin
          if (!data_mode) begin
            path_q <= lfwk_pkg::LFWK_PATH_CARRIER;
          end
        end
        default: begin
          path_q <= lfwk_pkg::LFWK_PATH_CARRIER;
        end
      endcase
    end
  end

  assign data_path_ready = (path_q == lfwk_pkg::LFWK_PATH_DATA);
  assign low_power_sniff_select =
    receiver_status_flags_q[`LFWK_BIT_SNIFF];
  assign carrier_mode_select = ctrl_q[`LFWK_CTRL_CARMODE];
  assign toggle_mode_select  = ctrl_q[`LFWK_CTRL_TOGGLE];

  // Unmapped addresses and hidden page-zero registers read as zero.
  // Read data stand for one cycle and then return to zero, so a late
  // sample never mistakes a stale value for a fresh read.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= `LFWK_BYTE_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        `LFWK_ADDR_CTRL:   rdata_q <= ctrl_q;
        `LFWK_ADDR_IRQEN:  rdata_q <= irqen_q;
        `LFWK_ADDR_STATUS: rdata_q <= page_zero ?
                             receiver_status_flags_q : 8'h00;
        `LFWK_ADDR_DATA:   rdata_q <= page_zero ?
                             received_byte_q : 8'h00;
        `LFWK_ADDR_IDH:    rdata_q <= page_zero ?
                             stored_id_high_q : 8'h00;
        `LFWK_ADDR_IDL:    rdata_q <= page_zero ?
                             stored_id_low_q : 8'h00;
        default:           rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // lfwk_status_regs

// ==== logic/lfwk_consts.svh ====
// Purpose: Offsets, field positions, reset values and timing of the LF
//          wake-up receiver register bank.
// Assumes: Included by its bare name from lfwk_status_regs only.
// Notes:   Definitions only.
`ifndef LFWK_CONSTS_SVH
`define LFWK_CONSTS_SVH

`define LFWK_ADDR_CTRL        8'h20
`define LFWK_ADDR_IRQEN       8'h21
`define LFWK_ADDR_STATUS      8'h24
`define LFWK_ADDR_DATA        8'h25
`define LFWK_ADDR_IDH         8'h26
`define LFWK_ADDR_IDL         8'h27

`define LFWK_BIT_DR           7
`define LFWK_BIT_ERR          6
`define LFWK_BIT_CD           5
`define LFWK_BIT_ID           4
`define LFWK_BIT_OV           3
`define LFWK_BIT_EOM          2
`define LFWK_BIT_SNIFF        1
`define LFWK_BIT_ACK          0
`define LFWK_FLAG_LO          2
`define LFWK_FLAG_HI          7

`define LFWK_CTRL_PAGE        7
`define LFWK_CTRL_CARMODE     6
`define LFWK_CTRL_TOGGLE      5
`define LFWK_CTRL_ID_CHECK_SELECT_HI    4
`define LFWK_CTRL_ID_CHECK_SELECT_LO    3
`define LFWK_CTRL_CC_HI       2
`define LFWK_CTRL_CC_LO       0

`define LFWK_STATUS_RESET     8'h02
`define LFWK_CTRL_RESET       8'h00
`define LFWK_IRQEN_RESET      8'h00
`define LFWK_BYTE_ZERO        8'h00
`define LFWK_CC_ONE           3'h1

`define LFWK_SNIFF_EXTRA_NS   200000
`define LFWK_CLK_PERIOD_PS    4000
`define LFWK_SNIFF_EXTRA_CYC  \
  ((`LFWK_SNIFF_EXTRA_NS * 1000 + `LFWK_CLK_PERIOD_PS - 1) \
   / `LFWK_CLK_PERIOD_PS)
`define LFWK_WAIT_W           17

`endif

// ==== logic/lfwk_pkg.sv ====
// Purpose: Types shared by the LF wake-up receiver register bank.
// Assumes: Constants live in lfwk_consts.svh.
// Notes:   Nothing here is imported; users write lfwk_pkg::name.
package lfwk_pkg;

  typedef enum logic [1:0] {
    LFWK_IDCHK_OFF,
    LFWK_IDCHK_HIGH,
    LFWK_IDCHK_LOW,
    LFWK_IDCHK_BOTH
  } lfwk_id_check_select_t;

  typedef enum logic [1:0] {
    LFWK_PATH_CARRIER,
    LFWK_PATH_WAKING,
    LFWK_PATH_DATA
  } lfwk_path_t;

endpackage

// ==== logic/lfwk_id_match.sv ====
// Purpose: Compare a received 16-bit ID with the stored ID bytes.
// Assumes: All inputs come from the same clock domain.
// Notes:   Purely combinational; the caller samples the result.
`timescale 1ns/1ps
module lfwk_id_match (
  input  wire logic [15:0] id_value,
  input  wire logic [7:0]  id_high_byte,
  input  wire logic [7:0]  id_low_byte,
  input  wire logic [1:0]  id_check_select,
  output logic             check_enabled,
  output logic             id_equal
);

  logic hi_eq;
  logic lo_eq;

  assign hi_eq = (id_value[15:8] == id_high_byte);
  assign lo_eq = (id_value[7:0] == id_low_byte);

  always_comb begin
    check_enabled = 1'b1;
    id_equal      = 1'b0;
    case (lfwk_pkg::lfwk_id_check_select_t'(id_check_select))
      lfwk_pkg::LFWK_IDCHK_OFF: begin
        check_enabled = 1'b0;
      end
      lfwk_pkg::LFWK_IDCHK_HIGH: begin
        id_equal = hi_eq;
      end
      lfwk_pkg::LFWK_IDCHK_LOW: begin
        id_equal = lo_eq;
      end
      lfwk_pkg::LFWK_IDCHK_BOTH: begin
        id_equal = hi_eq & lo_eq;
      end
      default: begin
        check_enabled = 1'b0;
      end
    endcase
  end

endmodule // lfwk_id_match

// ==== bench/lfwk_status_regs_checker.sv ====
// Purpose: Concurrent checks on the ports of the LF receiver status bank.
// Assumes: Page select and interrupt enables follow writes to 0x20/0x21.
// Notes:   Bound to lfwk_status_regs from the testbench top file.
`timescale 1ns/1ps
module lfwk_status_regs_checker (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       dec_byte_valid,
  input wire logic       dec_bit_error,
  input wire logic       dec_eom_violation,
  input wire logic       dec_carrier_valid,
  input wire logic       dec_id_valid,
  input wire logic       irq_req,
  input wire logic       low_power_sniff_select,
  input wire logic       carrier_mode_select,
  input wire logic       message_accept
);
  logic       page_q;
  logic [7:0] irqen_q;
  logic       any_ev;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  always_ff @(posedge clk_sys) begin
    if (rst) page_q <= 1'b0;
    else if (reg_wr && reg_addr == 8'h20) page_q <= reg_wdata[7];
  end
  always_ff @(posedge clk_sys) begin
    if (rst) irqen_q <= 8'h00;
    else if (reg_wr && reg_addr == 8'h21) irqen_q <= reg_wdata;
  end
  assign any_ev = dec_byte_valid | dec_bit_error | dec_eom_violation |
                  dec_carrier_valid | dec_id_valid;

  property p_ack_rd_zero;
    reg_rd && reg_addr == 8'h24 |=> !reg_rdata[0];
  endproperty
  a_ack_rd_zero: assert property (p_ack_rd_zero)
    else $error("acknowledge bit read as one");
  property p_page_hide;
    reg_rd && page_q && reg_addr inside {[8'h24:8'h27]} |=> reg_rdata == 8'h00;
  endproperty
  a_page_hide: assert property (p_page_hide)
    else $error("hidden register visible on page one");
  property p_id_rw;
    reg_wr && reg_addr == 8'h26 && !page_q ##1 !reg_wr ##1
      reg_rd && reg_addr == 8'h26 |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_id_rw: assert property (p_id_rw)
    else $error("stored id high byte not read back");
  property p_sniff_rst;
    $fell(rst) |-> low_power_sniff_select;
  endproperty
  a_sniff_rst: assert property (p_sniff_rst)
    else $error("sniff select not set by reset");
  property p_sniff_wr;
    reg_wr && reg_addr == 8'h24 && !page_q |=>
      low_power_sniff_select == $past(reg_wdata[1]);
  endproperty
  a_sniff_wr: assert property (p_sniff_wr)
    else $error("sniff select does not follow write");
  property p_dr_irq;
    dec_byte_valid && message_accept && !carrier_mode_select && irqen_q[7]
      && !(reg_wr && reg_addr == 8'h21) |=> irq_req;
  endproperty
  a_dr_irq: assert property (p_dr_irq)
    else $error("byte did not raise interrupt");
  property p_err_irq;
    dec_bit_error && message_accept && !carrier_mode_select && irqen_q[6]
      && !(reg_wr && reg_addr == 8'h21) |=> irq_req;
  endproperty
  a_err_irq: assert property (p_err_irq)
    else $error("bit error did not raise interrupt");
  property p_ack_clr;
    reg_wr && reg_addr == 8'h24 && reg_wdata[0] && !page_q && !any_ev
      |=> !irq_req;
  endproperty
  a_ack_clr: assert property (p_ack_clr)
    else $error("acknowledge left interrupt pending");
  property p_cd_quiet;
    carrier_mode_select && irqen_q == 8'h40 && !irq_req && !reg_wr
      |=> !irq_req;
  endproperty
  a_cd_quiet: assert property (p_cd_quiet)
    else $error("error flag set in carrier mode");
endmodule // lfwk_status_regs_checker

// ==== bench/lfwk_lf_sender.sv ====
// Purpose: Decoder-side model of the LF transmitter feeding event pulses.
// Assumes: Called by the testbench; one event set per call.
// Notes:   Event bits: byte, error, eom, carrier ok, carrier miss, id.
`timescale 1ns/1ps
module lfwk_lf_sender (
  input  wire logic        clk_sys,
  output logic             dec_byte_valid,
  output logic [7:0]       dec_byte_data,
  output logic             dec_bit_error,
  output logic             dec_eom_violation,
  output logic             dec_carrier_valid,
  output logic             dec_carrier_miss,
  output logic             dec_id_valid,
  output logic [15:0]      dec_id_value
);
  logic [5:0] ev_q = 6'h00;

  assign {dec_byte_valid, dec_bit_error, dec_eom_violation,
          dec_carrier_valid, dec_carrier_miss, dec_id_valid} = ev_q;
  initial begin
    dec_byte_data = 8'h00;
    dec_id_value  = 16'h0000;
  end

  task automatic send(input logic [5:0] e, input logic [7:0] b,
                      input logic [15:0] id);
    @(posedge clk_sys);
    ev_q          <= e;
    dec_byte_data <= b;
    dec_id_value  <= id;
    @(posedge clk_sys);
    ev_q          <= 6'h00;
    // Stale data is inverted so sampling outside the pulse shows up.
    dec_byte_data <= ~b;
    dec_id_value  <= ~id;
    #1;
  endtask
endmodule // lfwk_lf_sender

// ==== bench/lfwk_status_regs_tb.sv ====
// Purpose: Self-checking bench for the LF receiver status bank.
// Assumes: Sniff delay shortened to 8 cycles.
// Notes:   Register tasks follow the one-cycle strobe protocol.
`timescale 1ns/1ps
module lfwk_status_regs_tb;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata, dec_byte_data;
  logic [15:0] dec_id_value;
  logic        dec_byte_valid, dec_bit_error, dec_eom_violation;
  logic        dec_carrier_valid, dec_carrier_miss, dec_id_valid;
  logic        irq_req, low_power_sniff_select, carrier_mode_select;
  logic        toggle_mode_select, data_path_ready, message_accept;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          n_slow, n_fast;

  always #2 clk_sys = ~clk_sys;

  lfwk_status_regs #(.SNIFF_EXTRA_CYC(8)) uut (.clk_sys, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dec_byte_valid,
    .dec_byte_data, .dec_bit_error, .dec_eom_violation, .dec_carrier_valid,
    .dec_carrier_miss, .dec_id_valid, .dec_id_value, .irq_req,
    .low_power_sniff_select, .carrier_mode_select, .toggle_mode_select,
    .data_path_ready, .message_accept);
  lfwk_lf_sender lf (.clk_sys, .dec_byte_valid, .dec_byte_data,
    .dec_bit_error, .dec_eom_violation, .dec_carrier_valid,
    .dec_carrier_miss, .dec_id_valid, .dec_id_value);

  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk($sformatf("register %h", a), e, reg_rdata);
  endtask
  // Mode change must already have been taken when this starts.
  task automatic measure(output int n);
    n = 0;
    #1;
    while (n < 100 && data_path_ready !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 100) begin
      num_errors++;
      results();
    end
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rchk(8'h24, 8'h02);
    rchk(8'h27, 8'h00);
    chk("sniff select", 8'h01, {7'h00, low_power_sniff_select});
    wr(8'h26, 8'hA5);
    rchk(8'h26, 8'hA5);
    wr(8'h27, 8'h3C);
    rchk(8'h27, 8'h3C);
    $display("test reset_and_id done");
    wr(8'h21, 8'h80);
    lf.send(6'h20, 8'h5A, 16'h0000);
    rchk(8'h24, 8'h82);
    chk("irq", 8'h01, {7'h00, irq_req});
    rchk(8'h25, 8'h5A);
    rchk(8'h24, 8'h02);
    chk("irq", 8'h00, {7'h00, irq_req});
    wr(8'h25, 8'hFF);
    rchk(8'h25, 8'h5A);
    lf.send(6'h20, 8'h11, 16'h0000);
    lf.send(6'h20, 8'h22, 16'h0000);
    rchk(8'h24, 8'h8A);
    lf.send(6'h08, 8'h00, 16'h0000);
    rchk(8'h24, 8'h8E);
    rchk(8'h25, 8'h22);
    wr(8'h24, 8'h02);
    rchk(8'h24, 8'h0E);
    wr(8'h24, 8'h03);
    rchk(8'h24, 8'h02);
    $display("test data_flags done");
    wr(8'h21, 8'h40);
    lf.send(6'h10, 8'h00, 16'h0000);
    rchk(8'h24, 8'h42);
    chk("irq", 8'h01, {7'h00, irq_req});
    wr(8'h24, 8'h03);
    rchk(8'h24, 8'h02);
    chk("irq", 8'h00, {7'h00, irq_req});
    wr(8'h21, 8'h80);
    fork
      lf.send(6'h20, 8'h77, 16'h0000);
      wr(8'h24, 8'h03);
    join
    rchk(8'h24, 8'h82);
    rchk(8'h25, 8'h77);
    $display("test error_and_race done");
    wr(8'h21, 8'h10);
    wr(8'h20, 8'h18);
    lf.send(6'h01, 8'h00, 16'hA53C);
    rchk(8'h24, 8'h12);
    chk("irq", 8'h01, {7'h00, irq_req});
    wr(8'h24, 8'h03);
    lf.send(6'h01, 8'h00, 16'hA500);
    chk("accept", 8'h00, {7'h00, message_accept});
    lf.send(6'h20, 8'h99, 16'h0000);
    rchk(8'h24, 8'h02);
    $display("test id_filter done");
    wr(8'h20, 8'h42);
    chk("mode", 8'h01, {7'h00, carrier_mode_select});
    wr(8'h21, 8'h40);
    lf.send(6'h18, 8'h00, 16'h0000);
    rchk(8'h24, 8'h02);
    lf.send(6'h04, 8'h00, 16'h0000);
    rchk(8'h24, 8'h02);
    lf.send(6'h04, 8'h00, 16'h0000);
    rchk(8'h24, 8'h22);
    wr(8'h24, 8'h03);
    for (int i = 0; i < 4; i++) lf.send(6'h02 << i[0], 8'h00, 16'h0000);
    rchk(8'h24, 8'h02);
    wr(8'h20, 8'h62);
    chk("toggle", 8'h01, {7'h00, toggle_mode_select});
    lf.send(6'h04, 8'h00, 16'h0000);
    rchk(8'h24, 8'h22);
    $display("test carrier done");
    wr(8'h20, 8'h00);
    measure(n_slow);
    wr(8'h24, 8'h01);
    rchk(8'h24, 8'h00);
    wr(8'h20, 8'h40);
    wr(8'h20, 8'h00);
    measure(n_fast);
    chk("sniff delay", 8'h01, {7'h00, (n_slow - n_fast) >= 8});
    wr(8'h20, 8'h80);
    rchk(8'h24, 8'h00);
    wr(8'h26, 8'hFF);
    wr(8'h20, 8'h00);
    rchk(8'h26, 8'hA5);
    rchk(8'h30, 8'h00);
    $display("test sniff_and_page done");
    results();
  end
endmodule // lfwk_status_regs_tb

bind lfwk_status_regs lfwk_status_regs_checker u_chk (.clk_sys, .rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dec_byte_valid,
  .dec_bit_error, .dec_eom_violation, .dec_carrier_valid, .dec_id_valid,
  .irq_req, .low_power_sniff_select, .carrier_mode_select,
  .message_accept);
